// file: include/ccpt_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants, types and helpers for the timer group
package ccpt_pkg;

   localparam int              CCPT_NCH      = 4;      // channels per timer
   localparam int              CCPT_W16      = 16;     // standard counter width
   localparam int              CCPT_W32      = 32;     // wide counter width
   localparam int              CCPT_DTW      = 8;      // dead-time length field width
   localparam int              CCPT_PSW      = 5;      // wake period select width
   localparam logic [31:0]     CCPT_CNT_RST  = 32'h0000_0000; // counters after reset
   localparam logic [7:0]      CCPT_DT_RST   = 8'h00;  // dead-time down counter after reset
   localparam logic            CCPT_FLAG_RST = 1'b0;   // status flags after reset
   localparam logic            CCPT_OUT_RST  = 1'b0;   // channel outputs after reset

   // channel operating mode
   typedef enum logic [1:0] {
      CCPT_MODE_CAPTURE = 2'b00,
      CCPT_MODE_COMPARE = 2'b01,
      CCPT_MODE_PWM     = 2'b10
   } ccpt_mode_t;

   // capture input edge select
   typedef enum logic [1:0] {
      CCPT_EDGE_RISE = 2'b00,
      CCPT_EDGE_FALL = 2'b01,
      CCPT_EDGE_BOTH = 2'b10
   } ccpt_edge_t;

   // wake counter clock source
   typedef enum logic [1:0] {
      CCPT_SRC_XTAL = 2'b00,  // 32.768 khz crystal
      CCPT_SRC_RC   = 2'b01,  // 32.768 khz rc
      CCPT_SRC_ULF  = 2'b10   // 1 khz rc
   } ccpt_src_t;

   // software side and event side inputs of one timer
   typedef struct packed {
      logic                         run;       // counter enable
      logic                         evt_mode;  // count events instead of clocks
      logic                         dt_en;     // dead-time request
      logic [CCPT_DTW-1:0]          dt_len;    // dead-time in clocks, less one
      ccpt_mode_t [CCPT_NCH-1:0]    mode;      // per channel mode
      ccpt_edge_t [CCPT_NCH-1:0]    edge_sel;  // per channel capture edge
      logic [CCPT_NCH-1:0][31:0]    cmp;       // compare / pwm values
      logic [CCPT_NCH-1:0]          cap_in;    // capture inputs
      logic                         cnt_evt;   // event to count
      logic [CCPT_NCH-1:0]          flag_clr;  // flag clear strobes
   } ccpt_tmr_in_t;

   // results of one timer
   typedef struct packed {
      logic [31:0]                  cnt;       // counter value
      logic [CCPT_NCH-1:0][31:0]    cap;       // capture buffers
      logic [CCPT_NCH-1:0]          out_p;     // channel outputs
      logic [CCPT_NCH-1:0]          out_n;     // complementary outputs
      logic [CCPT_NCH-1:0]          flag;      // sticky status flags
      logic [CCPT_NCH-1:0]          match;     // fabric trigger per channel
      logic                         ovf;       // fabric trigger on wrap
   } ccpt_tmr_out_t;

   // always-on wake counter controls
   typedef struct packed {
      logic                         run;       // counter enable
      ccpt_src_t                    src;       // clock source select
      logic [CCPT_PSW-1:0]          psel;      // period is 2**psel ticks
      logic                         flag_clr;  // wake flag clear
   } ccpt_wake_in_t;

   // always-on wake counter results
   typedef struct packed {
      logic [31:0]                  cnt;       // counter value
      logic                         evt;       // fabric wake pulse
      logic                         flag;      // sticky wake flag
   } ccpt_wake_out_t;

   // edge detector used by capture inputs and wake sources
   function automatic logic ccpt_edge_hit(input logic prev, input logic cur,
                                          input ccpt_edge_t sel);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         CCPT_EDGE_RISE: hit = cur & ~prev;
         CCPT_EDGE_FALL: hit = prev & ~cur;
         CCPT_EDGE_BOTH: hit = cur ^ prev;
         default:        hit = 1'b0;
      endcase
      return hit;
   endfunction

endpackage

// file: src/ccpt_timers.sv
// How it works
// - standard timer: 16-bit counter, four channels
// - each channel: capture, compare or pwm
// - capture latches counter on selected edge
// - compare output shows counter versus threshold
// - pwm waveform follows successive compare values
// - dead-time only on standard instance zero
// - wide timer identical but 32-bit counter
// - dead-time only on wide instance zero
// - count events, send triggers to fabric
// - always-on 32-bit wake counter
// - wake clock from three low-rate sources
// - periodic wake events, selectable period

////////////////////////////////////////////////////////////////////////////////
// one timer unit: counter plus four channels
module ccpt_timer #(
   parameter int W  = 16,   // counter width
   parameter bit DT = 1'b0  // dead-time hardware present
) (
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   input  var  ccpt_pkg::ccpt_tmr_in_t  tin,
   output var  ccpt_pkg::ccpt_tmr_out_t tout
);
   import ccpt_pkg::*;

   logic [W-1:0]               cnt_reg;  // running counter
   logic                       ovf_reg;  // wrap trigger
   logic                       tick;     // counter advances this cycle
   logic                       wrap;     // counter leaves full scale
   logic                       dt_on;    // dead-time active for this unit
   logic [CCPT_NCH-1:0][31:0]  cap_w;    // capture buffers, widened
   logic [CCPT_NCH-1:0]        p_w;      // outputs
   logic [CCPT_NCH-1:0]        n_w;      // complementary outputs
   logic [CCPT_NCH-1:0]        flag_w;   // flags
   logic [CCPT_NCH-1:0]        match_w;  // trigger pulses

   // advance on every clock or on each counted event
   assign tick  = tin.run & (~tin.evt_mode | tin.cnt_evt);
   assign wrap  = tick & (&cnt_reg);
   // only instance zero carries the dead-time path
   assign dt_on = DT ? tin.dt_en : 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // counter, wraps to zero after full scale
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_reg <= CCPT_CNT_RST[W-1:0];
      end else if (tick) begin
         cnt_reg <= cnt_reg + W'(1);
      end
   end

   // wrap trigger for the event fabric
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ovf_reg <= 1'b0;
      end else begin
         ovf_reg <= wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // four channels on the shared counter
   for (genvar i = 0; i < CCPT_NCH; i++) begin : g_ch
      logic         cap_prev;   // last capture input level
      logic [W-1:0] cap_reg;    // capture buffer
      logic [W-1:0] pwm_thr;    // pwm threshold in use this period
      logic [W-1:0] cmp_thr;    // programmed threshold
      logic         cap_hit;    // capture event
      logic         hit;        // compare match
      logic         raw;        // undelayed channel level
      logic         raw_q;      // raw seen last cycle
      logic [7:0]   dt_cnt;     // dead-time down counter
      logic         p_reg;      // output
      logic         n_reg;      // complementary output
      logic         flag_reg;   // sticky flag
      logic         match_reg;  // trigger pulse

      assign cmp_thr = tin.cmp[i][W-1:0];
      assign cap_hit = (tin.mode[i] == CCPT_MODE_CAPTURE) &&
                       ccpt_edge_hit(cap_prev, tin.cap_in[i], tin.edge_sel[i]);

      // channel level and match per selected mode
      always_comb begin
         raw = 1'b0;
         hit = 1'b0;
         unique case (tin.mode[i])
            CCPT_MODE_COMPARE: begin
               raw = (cnt_reg >= cmp_thr);
               hit = tick && (cnt_reg == cmp_thr);
            end
            CCPT_MODE_PWM: begin
               raw = (cnt_reg < pwm_thr);
               hit = tick && (cnt_reg == pwm_thr);
            end
            CCPT_MODE_CAPTURE: begin
               raw = 1'b0;
               hit = 1'b0;
            end
            default: begin
               raw = 1'b0;
               hit = 1'b0;
            end
         endcase
      end

      // capture input history and buffer
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            cap_prev <= 1'b0;
            cap_reg  <= CCPT_CNT_RST[W-1:0];
         end else begin
            cap_prev <= tin.cap_in[i];
            if (cap_hit) begin
               cap_reg <= cnt_reg;
            end
         end
      end

      // pwm threshold reloads at wrap, or freely while stopped
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            pwm_thr <= CCPT_CNT_RST[W-1:0];
         end else if (wrap || !tin.run) begin
            pwm_thr <= cmp_thr;
         end
      end

      // sticky flag, a new event beats a clear in the same cycle
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            flag_reg <= CCPT_FLAG_RST;
         end else if (cap_hit || hit) begin
            flag_reg <= 1'b1;
         end else if (tin.flag_clr[i]) begin
            flag_reg <= 1'b0;
         end
      end

      // match trigger to the event fabric
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            match_reg <= 1'b0;
         end else begin
            match_reg <= hit | cap_hit;
         end
      end

      // output stage, with dead-time on both low for dt_len+1 clocks after each change
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            raw_q  <= 1'b0;
            dt_cnt <= CCPT_DT_RST;
            p_reg  <= CCPT_OUT_RST;
            n_reg  <= CCPT_OUT_RST;
         end else begin
            raw_q <= raw;
            if (!dt_on) begin
               // plain complementary pair
               dt_cnt <= CCPT_DT_RST;
               p_reg  <= raw;
               n_reg  <= ~raw;
            end else if (raw != raw_q) begin
               // edge seen, blank both outputs
               dt_cnt <= tin.dt_len;
               p_reg  <= 1'b0;
               n_reg  <= 1'b0;
            end else if (dt_cnt != CCPT_DT_RST) begin
               // still inside dead band
               dt_cnt <= dt_cnt - 8'h01;
            end else begin
               // dead band over
               p_reg <= raw_q;
               n_reg <= ~raw_q;
            end
         end
      end

      assign cap_w[i]   = 32'(cap_reg);
      assign p_w[i]     = p_reg;
      assign n_w[i]     = n_reg;
      assign flag_w[i]  = flag_reg;
      assign match_w[i] = match_reg;
   end

   // gather results
   assign tout = '{cnt: 32'(cnt_reg), cap: cap_w, out_p: p_w, out_n: n_w,
                   flag: flag_w, match: match_w, ovf: ovf_reg};

endmodule

////////////////////////////////////////////////////////////////////////////////
// timer group: two standard timers, one wide timer, wake counter
module ccpt_timers (
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   input  var  ccpt_pkg::ccpt_tmr_in_t   t16a_in,   // standard instance zero
   input  var  ccpt_pkg::ccpt_tmr_in_t   t16b_in,   // standard instance one
   input  var  ccpt_pkg::ccpt_tmr_in_t   w32_in,    // wide instance zero
   input  var  ccpt_pkg::ccpt_wake_in_t  wake_in,   // wake counter controls
   input  wire logic                     osc_xtal,  // low_freq_crystal_osc level
   input  wire logic                     osc_rc,    // low_freq_rc_osc level
   input  wire logic                     osc_ulf,   // ultra_low_freq_rc_osc level
   output var  ccpt_pkg::ccpt_tmr_out_t  t16a_out,
   output var  ccpt_pkg::ccpt_tmr_out_t  t16b_out,
   output var  ccpt_pkg::ccpt_tmr_out_t  w32_out,
   output var  ccpt_pkg::ccpt_wake_out_t wake_out
);
   import ccpt_pkg::*;

   logic        src_lvl;    // selected source level
   logic        src_prev;   // source level last cycle
   logic        wtick;      // wake counter advances
   logic [31:0] wcnt_reg;   // always_on_wake_counter value
   logic [31:0] wcnt_next;  // value after this tick
   logic [31:0] pmask;      // low bits that must be zero for a wake
   logic        wevt_reg;   // wake pulse
   logic        wflag_reg;  // sticky wake flag

   ////////////////////////////////////////////////////////////////////////////
   // timer instances
   ccpt_timer #(.W(CCPT_W16), .DT(1'b1)) u_t16a (
      .clk_sys (clk_sys),
      .reset   (reset),
      .tin     (t16a_in),
      .tout    (t16a_out)
   );

   ccpt_timer #(.W(CCPT_W16), .DT(1'b0)) u_t16b (
      .clk_sys (clk_sys),
      .reset   (reset),
      .tin     (t16b_in),
      .tout    (t16b_out)
   );

   ccpt_timer #(.W(CCPT_W32), .DT(1'b1)) u_w32 (
      .clk_sys (clk_sys),
      .reset   (reset),
      .tin     (w32_in),
      .tout    (w32_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // wake counter source select
   always_comb begin
      unique case (wake_in.src)
         CCPT_SRC_XTAL: src_lvl = osc_xtal;
         CCPT_SRC_RC:   src_lvl = osc_rc;
         CCPT_SRC_ULF:  src_lvl = osc_ulf;
         default:       src_lvl = 1'b0;
      endcase
   end

   assign wtick     = wake_in.run &
                      ccpt_edge_hit(src_prev, src_lvl, CCPT_EDGE_RISE);
   assign wcnt_next = wcnt_reg + 32'h0000_0001;
   assign pmask     = (32'h0000_0001 << wake_in.psel) - 32'h0000_0001;

   // source history for edge detection
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         src_prev <= 1'b0;
      end else begin
         src_prev <= src_lvl;
      end
   end

   // counter advances on each selected source rise while run is set, no sleep gating
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wcnt_reg <= CCPT_CNT_RST;
      end else if (wtick) begin
         wcnt_reg <= wcnt_next;
      end
   end

   // wake pulse each 2**psel source ticks
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wevt_reg <= 1'b0;
      end else begin
         wevt_reg <= wtick && ((wcnt_next & pmask) == 32'h0000_0000);
      end
   end

   // sticky wake flag, set beats clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wflag_reg <= CCPT_FLAG_RST;
      end else if (wevt_reg) begin
         wflag_reg <= 1'b1;
      end else if (wake_in.flag_clr) begin
         wflag_reg <= 1'b0;
      end
   end

   assign wake_out = '{cnt: wcnt_reg, evt: wevt_reg, flag: wflag_reg};

endmodule

// file: test/ccpt_osc_model.sv
////////////////////////////////////////////////////////////
// the three slow oscillators feeding the wake counter
module ccpt_osc_model (
   input  wire logic clk_sys,
   output var  logic osc_xtal,
   output var  logic osc_rc,
   output var  logic osc_ulf
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0; // cycle count
   // start low so the first rise is a clean tick
   initial begin
      osc_xtal = 1'b0;
      osc_rc = 1'b0;
      osc_ulf = 1'b0;
   end
   // square waves of distinct periods, moved at falling edges
   always @(negedge clk_sys) begin
      n <= n + 1;
      osc_xtal <= (n % 20) < 10;
      osc_rc <= (n % 24) < 12;
      osc_ulf <= (n % 60) < 30;
   end
endmodule

// file: test/ccpt_timers_monitor.sv
////////////////////////////////////////////////////////////
// port checker for the timer group
module ccpt_timers_monitor (
   input wire logic                     clk_sys,
   input wire logic                     reset,
   input var  ccpt_pkg::ccpt_tmr_in_t   t16a_in,
   input var  ccpt_pkg::ccpt_tmr_in_t   t16b_in,
   input var  ccpt_pkg::ccpt_tmr_in_t   w32_in,
   input var  ccpt_pkg::ccpt_wake_in_t  wake_in,
   input var  ccpt_pkg::ccpt_tmr_out_t  t16a_out,
   input var  ccpt_pkg::ccpt_tmr_out_t  t16b_out,
   input var  ccpt_pkg::ccpt_tmr_out_t  w32_out,
   input var  ccpt_pkg::ccpt_wake_out_t wake_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import ccpt_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // counter ticks of each timer
   wire logic tka = t16a_in.run & (~t16a_in.evt_mode | t16a_in.cnt_evt);
   wire logic tkb = t16b_in.run & (~t16b_in.evt_mode | t16b_in.cnt_evt);
   wire logic tkw = w32_in.run & (~w32_in.evt_mode | w32_in.cnt_evt);
   ////////////////////////////////////////////////////////////
   chk_cnt_step: assert property (tka |=>
      t16a_out.cnt[15:0] == $past(t16a_out.cnt[15:0]) + 16'h0001) else $error("missed tick");
   chk_cnt_freeze: assert property (!t16a_in.run |=> $stable(t16a_out.cnt))
      else $error("counter moved while stopped");
   chk_upper_zero: assert property (t16a_out.cnt[31:16] == 16'h0000)
      else $error("standard counter wider than 16 bits");
   chk_wrap_ovf: assert property (tkb && t16b_out.cnt[15:0] == 16'hffff |=>
      t16b_out.ovf && t16b_out.cnt == 32'h0) else $error("bad wrap");
   chk_wide_step: assert property (tkw |=> w32_out.cnt == $past(w32_out.cnt) + 32'h1)
      else $error("wide counter missed a tick");
   chk_cmp_level: assert property (t16b_in.mode[1] == CCPT_MODE_COMPARE |=>
      t16b_out.out_p[1] == ($past(t16b_out.cnt[15:0]) >= $past(t16b_in.cmp[1][15:0])))
      else $error("compare output wrong");
   chk_out_compl: assert property (!$past(reset) |-> t16b_out.out_n == ~t16b_out.out_p)
      else $error("outputs not complementary");
   chk_cap_latch: assert property (!$past(reset) && t16b_in.cap_in[0]
      && t16b_in.mode[0] == CCPT_MODE_CAPTURE && t16b_in.edge_sel[0] == CCPT_EDGE_RISE
      && !$past(t16b_in.cap_in[0])
      |=> t16b_out.cap[0] == $past(t16b_out.cnt) && t16b_out.flag[0] && t16b_out.match[0])
      else $error("capture missed");
   chk_flag_sticky: assert property (t16b_out.flag[0] && !t16b_in.flag_clr[0] |=>
      t16b_out.flag[0]) else $error("flag lost");
   chk_wake_flag: assert property (wake_out.evt |=> wake_out.flag)
      else $error("wake flag not set");
   chk_wake_period: assert property (wake_out.evt |->
      (wake_out.cnt & ((32'h1 << wake_in.psel) - 32'h1)) == 32'h0) else $error("bad wake period");
endmodule
bind ccpt_timers ccpt_timers_monitor i_mon (
   .clk_sys (clk_sys), .reset (reset), .t16a_in (t16a_in), .t16b_in (t16b_in),
   .w32_in (w32_in), .wake_in (wake_in), .t16a_out (t16a_out), .t16b_out (t16b_out),
   .w32_out (w32_out), .wake_out (wake_out));

// file: test/test_ccpt_timers.sv
////////////////////////////////////////////////////////////
// self-checking bench for the timer group
module test_ccpt_timers;
   timeunit 1ns;
   timeprecision 1ns;
   import ccpt_pkg::*;
   logic           clk_sys = 1'b0; // system clock
   logic           reset   = 1'b1; // synchronous reset
   ccpt_tmr_in_t   ta, tb, tw;     // timer inputs
   ccpt_wake_in_t  wk;             // wake controls
   ccpt_tmr_out_t  oa, ob, ow;     // timer results
   ccpt_wake_out_t wo;             // wake results
   logic           ox, orc, ou;    // slow oscillators
   logic [31:0]    v;              // saved counter value
   int             n_fail = 0;
   int             checks = 0;
   always #5 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////
   ccpt_timers i_dut (
      .clk_sys (clk_sys), .reset (reset), .t16a_in (ta), .t16b_in (tb), .w32_in (tw),
      .wake_in (wk), .osc_xtal (ox), .osc_rc (orc), .osc_ulf (ou), .t16a_out (oa),
      .t16b_out (ob), .w32_out (ow), .wake_out (wo));
   ccpt_osc_model i_osc (.clk_sys (clk_sys), .osc_xtal (ox), .osc_rc (orc), .osc_ulf (ou));
   ////////////////////////////////////////////////////////////
   // compare one result
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // pass k falling edges
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   task automatic done(input string s);
      $display("test %0s finished", s);
   endtask
   task automatic end_of_test;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // bounded wait for a wake pulse
   task automatic wait_evt;
      int i;
      i = 0;
      while (wo.evt !== 1'b1 && i < 500) begin
         cyc(1);
         i++;
      end
      if (wo.evt !== 1'b1) begin
         n_fail++;
         end_of_test;
      end
   endtask
   // channel 2 as dead-time compare, other channels capture
   function automatic ccpt_tmr_in_t prep();
      ccpt_tmr_in_t t;
      t = '0;
      t.mode[2] = CCPT_MODE_COMPARE;
      t.cmp[2] = '1;
      t.dt_en = 1'b1;
      t.dt_len = 8'h02;
      return t;
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      ta = prep();
      tb = prep();
      tw = prep();
      tb.mode[1] = CCPT_MODE_COMPARE;
      wk = '0;
      cyc(8);
      reset = 1'b0;
      chk(oa.cnt, 32'h0);
      chk(ob.flag, 32'h0);
      chk(wo.cnt, 32'h0);
      done("reset");
      // clock counting, hold, then event counting
      ta.run = 1'b1;
      cyc(5);
      chk(oa.cnt, 32'h5);
      ta.run = 1'b0;
      cyc(3);
      chk(oa.cnt, 32'h5);
      ta.run = 1'b1;
      ta.evt_mode = 1'b1;
      repeat (3) begin
         ta.cnt_evt = 1'b1;
         cyc(1);
         ta.cnt_evt = 1'b0;
         cyc(2);
      end
      chk(oa.cnt, 32'h8);
      ta.run = 1'b0;
      done("count");
      // capture on a rising input, then flag clear
      tb.run = 1'b1;
      cyc(4);
      v = ob.cnt;
      tb.cap_in[0] = 1'b1;
      cyc(1);
      chk(ob.cap[0], v);
      chk(ob.flag[0], 1'b1);
      tb.flag_clr[0] = 1'b1;
      cyc(1);
      tb.flag_clr[0] = 1'b0;
      cyc(1);
      chk(ob.flag[0], 1'b0);
      done("capture");
      // compare threshold one above and equal to the held count
      tb.run = 1'b0;
      cyc(1);
      v = ob.cnt;
      tb.cmp[1] = v + 32'h1;
      tb.flag_clr[1] = 1'b1;
      cyc(2);
      tb.flag_clr[1] = 1'b0;
      chk(ob.out_p[1], 1'b0);
      chk(ob.flag[1], 1'b0);
      tb.cmp[1] = v;
      cyc(1);
      chk(ob.out_p[1], 1'b1);
      // run to the wrap, passing the match
      tb.run = 1'b1;
      cyc(1);
      chk(ob.match[1], 1'b1);
      chk(ob.flag[1], 1'b1);
      cyc(65535 - int'(v));
      chk(ob.cnt, 32'h0);
      chk(ob.ovf, 1'b1);
      chk(ob.flag[1], 1'b1);
      tb.run = 1'b0;
      done("compare");
      // wide pwm, threshold reloaded while stopped
      tw.mode[3] = CCPT_MODE_PWM;
      tw.cmp[3] = 32'h4;
      cyc(5);
      tw.run = 1'b1;
      cyc(4);
      chk(ow.cnt, 32'h4);
      chk(ow.out_p[3], 1'b1);
      cyc(1);
      chk(ow.out_p[3], 1'b0);
      tw.run = 1'b0;
      tw.cmp[3] = 32'h8;
      cyc(6);
      chk(ow.out_p[3], 1'b1);
      done("pwm");
      // dead-time on instance zero of each width only
      ta.cmp[2] = 32'h0;
      tb.cmp[2] = 32'h0;
      tw.cmp[2] = 32'h0;
      cyc(1);
      chk(ob.out_p[2], 1'b1);
      chk(oa.out_p[2], 1'b0);
      cyc(2);
      chk(oa.out_n[2], 1'b0);
      chk(ow.out_n[2], 1'b0);
      cyc(1);
      chk(oa.out_p[2], 1'b1);
      chk(ow.out_p[2], 1'b1);
      done("deadtime");
      // wake events, sources, freeze and clear
      wk.run = 1'b1;
      wk.psel = 5'h02;
      wait_evt;
      chk(wo.cnt[1:0], 2'h0);
      cyc(1);
      chk(wo.flag, 1'b1);
      for (int s = 0; s < 4; s++) begin
         wk.src = ccpt_src_t'(s);
         cyc(2);
         v = wo.cnt;
         cyc(150);
         chk(wo.cnt !== v, s != 3);
      end
      wk.run = 1'b0;
      wk.src = CCPT_SRC_XTAL;
      v = wo.cnt;
      wk.flag_clr = 1'b1;
      cyc(1);
      wk.flag_clr = 1'b0;
      cyc(50);
      chk(wo.cnt, v);
      chk(wo.flag, 1'b0);
      done("wake");
      end_of_test;
   end
endmodule
